// ===== logic/eeprom_access_pkg.sv
// Purpose: Shared constants for the EEPROM access controller and its CPU-side end
// Assumes: 250 MHz system clock, byte-wide I/O register port
// Notes:   Offsets are register indices on the two-bit I/O select
package eeprom_access_pkg;
   localparam int unsigned CLOCK_KHZ        = 250000;
   localparam int unsigned ADDR_BITS        = 11;
   localparam int unsigned ARRAY_BYTES      = 2048;
   localparam int unsigned WRITE_RC_CYCLES  = 27072;
   localparam int unsigned WRITE_TIME_US    = 3400;
   // Clocks per RC oscillator cycle, from the typical write time
   localparam int unsigned RC_DIV =
      (CLOCK_KHZ * WRITE_TIME_US / 1000) / WRITE_RC_CYCLES;
   localparam logic [2:0]  READ_STALL_CYCLES  = 3'h4;
   localparam logic [2:0]  WRITE_STALL_CYCLES = 3'h2;
   localparam logic [2:0]  MWE_WINDOW_CYCLES  = 3'h4;

   // Device register indices
   localparam logic [1:0]  OFS_CONTROL   = 2'h0;
   localparam logic [1:0]  OFS_DATA      = 2'h1;
   localparam logic [1:0]  OFS_ADDR_LOW  = 2'h2;
   localparam logic [1:0]  OFS_ADDR_HIGH = 2'h3;

   // Control field positions
   localparam int unsigned BIT_READ_STROBE  = 0;
   localparam int unsigned BIT_WRITE_STROBE = 1;
   localparam int unsigned BIT_MASTER_WE    = 2;
   localparam int unsigned BIT_READY_IE     = 3;
   localparam logic [7:0]  CONTROL_RESET    = 8'h00;
   localparam logic [7:0]  DATA_RESET       = 8'h00;

   // CPU-side end register indices
   localparam logic [2:0]  HOFS_COMMAND = 3'h0;
   localparam logic [2:0]  HOFS_ADDR_LO = 3'h1;
   localparam logic [2:0]  HOFS_ADDR_HI = 3'h2;
   localparam logic [2:0]  HOFS_WDATA   = 3'h3;
   localparam logic [2:0]  HOFS_CONFIG  = 3'h4;
   localparam logic [2:0]  HOFS_STATUS  = 3'h5;
   localparam logic [2:0]  HOFS_RDATA   = 3'h6;
   localparam int unsigned CMD_WRITE    = 0;
   localparam int unsigned CMD_READ     = 1;
   localparam int unsigned CFG_READY_IE = 0;
   localparam int unsigned CFG_GLOBAL_IE = 1;
endpackage

// ===== logic/eeprom_if.sv
// Purpose: I/O register link between the CPU side and the EEPROM access controller
// Assumes: One clock; read data return one cycle after the read strobe
// Notes:   No clocking block; both ends are design modules
`timescale 1ns/1ps
`default_nettype none
interface eeprom_if;
   logic [1:0] busAddr;
   logic [7:0] busWdata;
   logic       busWrite;
   logic       busRead;
   logic [7:0] busRdata;
   logic       cpuStall;
   logic       readyIrq;
   logic       globalIrqEnable;
   logic       flashSelfprogBusy;

   modport device (
      input  busAddr, busWdata, busWrite, busRead, globalIrqEnable, flashSelfprogBusy,
      output busRdata, cpuStall, readyIrq
   );
   modport host (
      output busAddr, busWdata, busWrite, busRead, globalIrqEnable, flashSelfprogBusy,
      input  busRdata, cpuStall, readyIrq
   );
endinterface
`default_nettype wire

// ===== logic/eeprom_device_end.sv
// Purpose: EEPROM access controller: address, data and control registers and array
// Assumes: porRst is the power-on reset only; rst is the ordinary system reset
// Notes:   The write engine ignores rst so a write in flight still lands
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Accepted read stalls CPU four cycles
// - Accepted write strobe stalls CPU two cycles
// - Eleven-bit linear byte address
// - Address bits 15..11 read zero
// - Software loads address before any access
// - Data register holds write byte, read result
// - Control bit 3 enables ready interrupt
// - Ready interrupt is a level while idle
// - Write strobe acts only within master-enable window
// - Master enable self-clears after four cycles
// - Write lasts 27072 RC oscillator cycles
// - Write strobe bit reads as busy flag
// - Busy refuses reads and freezes address
// - No write during flash self-programming
// - Software waits for both busy flags
// - Software sets master enable, then strobe
// - Software masks interrupts during sequence
// - Read result ready right after strobe
// - Software checks busy before reading
// - Control bits 7..4 read zero
// - Write completes in power-down, clock runs
// - Write in flight survives a reset
module eeprom_device_end #(
   parameter int unsigned WRITE_CYCLES = eeprom_access_pkg::WRITE_RC_CYCLES,
   parameter int unsigned RC_DIVIDE    = eeprom_access_pkg::RC_DIV
) (
   input  wire logic      clock,
   input  wire logic      rst,
   input  wire logic      porRst,
   eeprom_if.device       link,
   input  wire logic      powerDownReq,
   output logic           writeBusy,
   output logic           rcClockRunning,
   output logic           powerDownReady
);
   import eeprom_access_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0]            array_mem [ARRAY_BYTES];
   logic [ADDR_BITS-1:0]  byteAddr_reg;
   logic [7:0]            dataByte_reg;
   logic                  readyIe_reg;
   logic [2:0]            mweCount_reg;
   logic [2:0]            stallCount_reg;
   logic                  stall_reg;
   logic [7:0]            rdata_reg;
   logic                  irq_reg;
   logic                  busy_reg;
   logic [ADDR_BITS-1:0]  wrAddr_reg;
   logic [7:0]            wrData_reg;
   logic [15:0]           rcDiv_reg;
   logic [15:0]           rcCount_reg;
   logic                  rcTick;
   logic                  writeLast;
   logic                  ctrlWrite;
   logic                  readAccept;
   logic                  writeAccept;
   logic [7:0]            controlView;

   assign ctrlWrite   = link.busWrite && (link.busAddr == OFS_CONTROL);
   assign readAccept  = ctrlWrite && link.busWdata[BIT_READ_STROBE] && !busy_reg;
   // Strobe counts only inside the window opened by an earlier master-enable write
   assign writeAccept = ctrlWrite && link.busWdata[BIT_WRITE_STROBE]
                        && (mweCount_reg != 3'h0)
                        && !busy_reg
                        && !link.flashSelfprogBusy;
   assign controlView = {4'h0, readyIe_reg, (mweCount_reg != 3'h0), busy_reg, 1'b0};

   ////////////////////////////////////////////////////////////////////////////////
   // Address and data registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         byteAddr_reg <= '0;
      end else if (link.busWrite && !busy_reg) begin
         if (link.busAddr == OFS_ADDR_LOW) begin
            byteAddr_reg[7:0] <= link.busWdata;
         end else if (link.busAddr == OFS_ADDR_HIGH) begin
            byteAddr_reg[ADDR_BITS-1:8] <= link.busWdata[ADDR_BITS-9:0];
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dataByte_reg <= DATA_RESET;
      end else if (readAccept) begin
         dataByte_reg <= array_mem[byteAddr_reg];
      end else if (link.busWrite && (link.busAddr == OFS_DATA)) begin
         dataByte_reg <= link.busWdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         readyIe_reg <= CONTROL_RESET[BIT_READY_IE];
      end else if (ctrlWrite) begin
         readyIe_reg <= link.busWdata[BIT_READY_IE];
      end
   end

   // Window closes on its own, or at once when a write is launched
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mweCount_reg <= 3'h0;
      end else if (writeAccept) begin
         mweCount_reg <= 3'h0;
      end else if (ctrlWrite && link.busWdata[BIT_MASTER_WE]) begin
         mweCount_reg <= MWE_WINDOW_CYCLES;
      end else if (mweCount_reg != 3'h0) begin
         mweCount_reg <= mweCount_reg - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // CPU stall
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stallCount_reg <= 3'h0;
         stall_reg      <= 1'b0;
      end else if (readAccept) begin
         stallCount_reg <= READ_STALL_CYCLES - 3'h1;
         stall_reg      <= 1'b1;
      end else if (writeAccept) begin
         stallCount_reg <= WRITE_STALL_CYCLES - 3'h1;
         stall_reg      <= 1'b1;
      end else begin
         stall_reg <= (stallCount_reg != 3'h0);
         if (stallCount_reg != 3'h0) begin
            stallCount_reg <= stallCount_reg - 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe; unmapped cannot occur on two bits
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else if (link.busRead) begin
         case (link.busAddr)
            OFS_CONTROL:   rdata_reg <= controlView;
            OFS_DATA:      rdata_reg <= dataByte_reg;
            OFS_ADDR_LOW:  rdata_reg <= byteAddr_reg[7:0];
            OFS_ADDR_HIGH: rdata_reg <= {5'h00, byteAddr_reg[ADDR_BITS-1:8]};
            default:       rdata_reg <= 8'h00;
         endcase
      end
   end

   // Level request while idle; global enable comes from the host end's config register, held off during a sequence
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= readyIe_reg && link.globalIrqEnable && !busy_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write engine on power-on reset only, so a system reset cannot cut a write short
   assign rcTick    = busy_reg && (rcDiv_reg == 16'(RC_DIVIDE - 1));
   assign writeLast = rcTick && (rcCount_reg == 16'(WRITE_CYCLES - 1));

   always_ff @(posedge clock or posedge porRst) begin
      if (porRst) begin
         rcDiv_reg <= 16'h0000;
      end else if (!busy_reg || rcTick) begin
         rcDiv_reg <= 16'h0000;
      end else begin
         rcDiv_reg <= rcDiv_reg + 16'h0001;
      end
   end

   always_ff @(posedge clock or posedge porRst) begin
      if (porRst) begin
         busy_reg    <= 1'b0;
         rcCount_reg <= 16'h0000;
      end else if (writeAccept) begin
         busy_reg    <= 1'b1;
         rcCount_reg <= 16'h0000;
      end else if (writeLast) begin
         busy_reg    <= 1'b0;
      end else if (rcTick) begin
         rcCount_reg <= rcCount_reg + 16'h0001;
      end
   end

   // Operands frozen at launch so later register traffic cannot corrupt them
   always_ff @(posedge clock or posedge porRst) begin
      if (porRst) begin
         wrAddr_reg <= '0;
         wrData_reg <= 8'h00;
      end else if (writeAccept) begin
         wrAddr_reg <= byteAddr_reg;
         wrData_reg <= dataByte_reg;
      end
   end

   // Array has no reset: it is the nonvolatile contents
   always_ff @(posedge clock) begin
      if (writeLast) begin
         array_mem[wrAddr_reg] <= wrData_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sleep handshake: the timing clock keeps running until the write ends
   always_ff @(posedge clock or posedge porRst) begin
      if (porRst) begin
         rcClockRunning <= 1'b0;
         powerDownReady <= 1'b0;
         writeBusy      <= 1'b0;
      end else begin
         rcClockRunning <= busy_reg || writeAccept;
         powerDownReady <= powerDownReq && !busy_reg && !writeAccept;
         writeBusy      <= busy_reg || writeAccept;
      end
   end

   assign link.busRdata = rdata_reg;
   assign link.cpuStall = stall_reg;
   assign link.readyIrq = irq_reg;
endmodule
`default_nettype wire

// ===== logic/eeprom_host_end.sv
// Purpose: CPU-side sequencer that runs timed EEPROM read and write sequences
// Assumes: Device end answers register reads one cycle later and holds cpuStall
// Notes:   One command at a time; commands during a sequence are dropped
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_end (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [2:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [7:0]  regRdata,
   input  wire logic        flashSelfprogBusy,
   eeprom_if.host           link
);
   import eeprom_access_pkg::*;

   typedef enum {S_IDLE, S_POLL, S_POLL_CHK, S_ADDR_HI, S_ADDR_LO, S_DATA, S_MWE, S_WE,
                 S_RE, S_RD_DATA, S_RD_CAP, S_POLL_WAIT, S_RD_WAIT} host_state_e;

   host_state_e state_reg;
   logic        isWrite_reg;
   logic [7:0]  addrLo_reg;
   logic [7:0]  addrHi_reg;
   logic [7:0]  wdata_reg;
   logic [7:0]  rdataHold_reg;
   logic [1:0]  config_reg;
   logic        devBusy_reg;
   logic [1:0]  busAddr_reg;
   logic [7:0]  busWdata_reg;
   logic        busWrite_reg;
   logic        busRead_reg;
   logic        gie_reg;
   logic        flashBusy_reg;
   logic        go;
   logic [7:0]  ctrlBase;

   assign go       = !link.cpuStall;
   assign ctrlBase = {4'h0, config_reg[CFG_READY_IE], 3'h0};

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         addrLo_reg <= 8'h00;
         addrHi_reg <= 8'h00;
         wdata_reg  <= 8'h00;
         config_reg <= 2'h0;
      end else if (regWrite) begin
         case (regAddr)
            HOFS_ADDR_LO: addrLo_reg <= regWdata;
            HOFS_ADDR_HI: addrHi_reg <= regWdata;
            HOFS_WDATA:   wdata_reg  <= regWdata;
            HOFS_CONFIG:  config_reg <= regWdata[1:0];
            default:      config_reg <= config_reg;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            HOFS_ADDR_LO: regRdata <= addrLo_reg;
            HOFS_ADDR_HI: regRdata <= addrHi_reg;
            HOFS_WDATA:   regRdata <= wdata_reg;
            HOFS_CONFIG:  regRdata <= {6'h00, config_reg};
            HOFS_STATUS:  regRdata <= {5'h00, devBusy_reg, link.readyIrq, state_reg != S_IDLE};
            HOFS_RDATA:   regRdata <= rdataHold_reg;
            default:      regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

   // Interrupts held off for the whole sequence so the window cannot time out
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gie_reg       <= 1'b0;
         flashBusy_reg <= 1'b0;
      end else begin
         gie_reg       <= config_reg[CFG_GLOBAL_IE] && (state_reg == S_IDLE);
         flashBusy_reg <= flashSelfprogBusy;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer; each bus access except the write strobe holds off while cpuStall is high, but the data read follows the read strobe before its stall rises
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg     <= S_IDLE;
         isWrite_reg   <= 1'b0;
         devBusy_reg   <= 1'b0;
         rdataHold_reg <= 8'h00;
         busAddr_reg   <= OFS_CONTROL;
         busWdata_reg  <= 8'h00;
         busWrite_reg  <= 1'b0;
         busRead_reg   <= 1'b0;
      end else begin
         busWrite_reg <= 1'b0;
         busRead_reg  <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (regWrite && (regAddr == HOFS_COMMAND)
                   && (regWdata[CMD_WRITE] || regWdata[CMD_READ])) begin
                  isWrite_reg <= regWdata[CMD_WRITE];
                  state_reg   <= S_POLL;
               end
            end
            S_POLL: begin
               if (go) begin
                  busAddr_reg <= OFS_CONTROL;
                  busRead_reg <= 1'b1;
                  state_reg   <= S_POLL_WAIT;
               end
            end
            S_POLL_CHK: begin
               devBusy_reg <= link.busRdata[BIT_WRITE_STROBE];
               if (link.busRdata[BIT_WRITE_STROBE] || (isWrite_reg && flashBusy_reg)) begin
                  state_reg <= S_POLL;
               end else begin
                  state_reg <= S_ADDR_HI;
               end
            end
            S_ADDR_HI: begin
               if (go) begin
                  busAddr_reg  <= OFS_ADDR_HIGH;
                  busWdata_reg <= addrHi_reg;
                  busWrite_reg <= 1'b1;
                  state_reg    <= S_ADDR_LO;
               end
            end
            S_ADDR_LO: begin
               if (go) begin
                  busAddr_reg  <= OFS_ADDR_LOW;
                  busWdata_reg <= addrLo_reg;
                  busWrite_reg <= 1'b1;
                  state_reg    <= isWrite_reg ? S_DATA : S_RE;
               end
            end
            S_DATA: begin
               if (go) begin
                  busAddr_reg  <= OFS_DATA;
                  busWdata_reg <= wdata_reg;
                  busWrite_reg <= 1'b1;
                  state_reg    <= S_MWE;
               end
            end
            S_MWE: begin
               if (go) begin
                  busAddr_reg  <= OFS_CONTROL;
                  busWdata_reg <= ctrlBase | (8'h01 << BIT_MASTER_WE);
                  busWrite_reg <= 1'b1;
                  state_reg    <= S_WE;
               end
            end
            S_WE: begin
               // Next cycle after master enable: well inside the window
               busAddr_reg  <= OFS_CONTROL;
               busWdata_reg <= ctrlBase | (8'h01 << BIT_WRITE_STROBE);
               busWrite_reg <= 1'b1;
               state_reg    <= S_IDLE;
            end
            S_RE: begin
               if (go) begin
                  busAddr_reg  <= OFS_CONTROL;
                  busWdata_reg <= ctrlBase | (8'h01 << BIT_READ_STROBE);
                  busWrite_reg <= 1'b1;
                  state_reg    <= S_RD_DATA;
               end
            end
            S_RD_DATA: begin
               if (go) begin
                  busAddr_reg <= OFS_DATA;
                  busRead_reg <= 1'b1;
                  state_reg   <= S_RD_WAIT;
               end
            end
            S_RD_CAP: begin
               rdataHold_reg <= link.busRdata;
               state_reg     <= S_IDLE;
            end
            // Device answers a read in the cycle after its strobe
            S_POLL_WAIT: state_reg <= S_POLL_CHK;
            S_RD_WAIT:   state_reg <= S_RD_CAP;
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   assign link.busAddr           = busAddr_reg;
   assign link.busWdata          = busWdata_reg;
   assign link.busWrite          = busWrite_reg;
   assign link.busRead           = busRead_reg;
   assign link.globalIrqEnable   = gie_reg;
   assign link.flashSelfprogBusy = flashBusy_reg;
endmodule
`default_nettype wire

// ===== sim/eeprom_link_asserts.sv
// Purpose: Timing checks on the link between host end and device end
// Assumes: Host end sends one strobe kind per control write
// Notes:   Age and run counters saturate at 7
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_asserts
   import eeprom_access_pkg::*;
(
   input wire logic       clock,
   input wire logic       rst,
   input wire logic [1:0] busAddr,
   input wire logic [7:0] busWdata,
   input wire logic       busWrite,
   input wire logic       busRead,
   input wire logic [7:0] busRdata,
   input wire logic       cpuStall,
   input wire logic       readyIrq,
   input wire logic       globalIrqEnable
);
   logic       ctlWr;
   logic [2:0] mweAge_reg;
   logic [2:0] stallRun_reg;
   assign ctlWr = busWrite && busAddr == OFS_CONTROL;
   ////////////////////////////////////////////////////////////
   // Cycles since master enable was written, to judge its timeout
   always_ff @(posedge clock or posedge rst) begin
      if (rst) mweAge_reg <= 3'h7;
      else if (ctlWr && busWdata[BIT_MASTER_WE]) mweAge_reg <= 3'h1;
      else if (mweAge_reg != 3'h7) mweAge_reg <= mweAge_reg + 3'h1;
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) stallRun_reg <= 3'h0;
      else if (!cpuStall) stallRun_reg <= 3'h0;
      else if (stallRun_reg != 3'h7) stallRun_reg <= stallRun_reg + 3'h1;
   end
   ////////////////////////////////////////////////////////////
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   chk_stall_has_cause: assert property ($rose(cpuStall) |->
      $past(ctlWr && busWdata[1:0] != 2'h0)) else $error("stall without strobe");
   chk_read_stall_len: assert property ((ctlWr && busWdata[1:0] == 2'h1) ##1 cpuStall
      |-> cpuStall [*4] ##1 !cpuStall) else $error("read stall not four cycles");
   chk_write_stall_len: assert property ((ctlWr && busWdata[1:0] == 2'h2) ##1 cpuStall
      |-> cpuStall [*2] ##1 !cpuStall) else $error("write stall not two cycles");
   chk_stall_run_bound: assert property (stallRun_reg <= 3'h4)
      else $error("stall longer than four cycles");
   chk_ctl_reserved_zero: assert property (busRead && busAddr == OFS_CONTROL
      |=> busRdata[7:4] == 4'h0 && !busRdata[BIT_READ_STROBE]) else $error("control reserved set");
   chk_mwe_self_clear: assert property (busRead && busAddr == OFS_CONTROL && mweAge_reg >= 3'h5
      |=> !busRdata[BIT_MASTER_WE]) else $error("master enable did not time out");
   chk_irq_global_gate: assert property (readyIrq |-> $past(globalIrqEnable))
      else $error("ready irq without global enable");
   chk_irq_busy_drop: assert property ((ctlWr && busWdata[1:0] == 2'h2) ##1 cpuStall
      |-> ##1 !readyIrq [*2]) else $error("ready irq high while busy");
   chk_mwe_irq_masked: assert property (ctlWr && busWdata[BIT_MASTER_WE] |-> !globalIrqEnable)
      else $error("interrupts open during write sequence");
   cov_read_stall: cover property ((ctlWr && busWdata[1:0] == 2'h1) ##1 cpuStall);
   cov_write_stall: cover property ((ctlWr && busWdata[1:0] == 2'h2) ##1 cpuStall);
   cov_ready_irq: cover property (readyIrq);
endmodule
`default_nettype wire

// ===== sim/tb_eeprom_access_controller.sv
// Purpose: Self-checking bench for both ends of the EEPROM link
// Assumes: Write time shortened through WRITE_CYCLES and RC_DIVIDE
// Notes:   A second device end is driven raw to break the write sequence
`timescale 1ns/1ps
`default_nettype none
module tb_eeprom_access_controller import eeprom_access_pkg::*;;
   localparam int unsigned WC = 8;
   localparam int unsigned RD = 2;
   logic       clock, rst, porRst, regWrite, regRead, fBusy, pdReq, wb, rcRun, pdRdy, wb2;
   logic [2:0] regAddr;
   logic [7:0] regWdata, regRdata, s;
   logic [10:0] ta [3] = '{11'h7FF, 11'h3FF, 11'h000};
   logic [7:0]  td [3] = '{8'h5A, 8'hC3, 8'hA5};
   int          err_count, total_checks, n;
   eeprom_if l1 ();
   eeprom_if l2 ();
   eeprom_device_end #(.WRITE_CYCLES(WC), .RC_DIVIDE(RD)) eeprom_device_end_i (.clock(clock),
      .rst(rst), .porRst(porRst), .link(l1), .powerDownReq(pdReq), .writeBusy(wb),
      .rcClockRunning(rcRun), .powerDownReady(pdRdy));
   eeprom_device_end #(.WRITE_CYCLES(WC), .RC_DIVIDE(RD)) eeprom_device_end_raw_i (.clock(clock),
      .rst(rst), .porRst(porRst), .link(l2), .powerDownReq(1'b0), .writeBusy(wb2),
      .rcClockRunning(), .powerDownReady());
   eeprom_host_end eeprom_host_end_i (.clock(clock), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .flashSelfprogBusy(fBusy), .link(l1));
   eeprom_link_asserts eeprom_link_asserts_i (.clock(clock), .rst(rst), .busAddr(l1.busAddr),
      .busWdata(l1.busWdata), .busWrite(l1.busWrite), .busRead(l1.busRead),
      .busRdata(l1.busRdata), .cpuStall(l1.cpuStall), .readyIrq(l1.readyIrq),
      .globalIrqEnable(l1.globalIrqEnable));
   ////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk8({7'h00, g}, {7'h00, e});
   endtask
   task automatic hw(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
      regWdata <= ~d;
   endtask
   task automatic hr(input logic [2:0] a);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 s = regRdata;
   endtask
   task automatic hwait();
      int k = 0;
      hr(HOFS_STATUS);
      while (s[0] !== 1'b0 && k < 300) begin
         hr(HOFS_STATUS);
         k++;
      end
      chk1(s[0], 1'b0);
   endtask
   task automatic hop(input logic [7:0] c, input logic [10:0] ad, input logic [7:0] d);
      hw(HOFS_ADDR_LO, ad[7:0]);
      hw(HOFS_ADDR_HI, {5'h00, ad[10:8]});
      hw(HOFS_WDATA, d);
      hw(HOFS_COMMAND, c);
   endtask
   task automatic rb(input logic [10:0] ad, input logic [7:0] e);
      hop(8'h02, ad, 8'h00);
      hwait();
      hr(HOFS_RDATA);
      chk8(s, e);
   endtask
   // Bounded wait; n ends as the number of edges waited
   task automatic wt(input logic v, input logic raw);
      #1 n = 0;
      while ((raw ? wb2 : wb) !== v && n < 100) begin
         @(posedge clock);
         #1 n++;
      end
   endtask
   task automatic dw(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      l2.busAddr <= a;
      l2.busWdata <= d;
      l2.busWrite <= 1'b1;
      @(posedge clock);
      l2.busWrite <= 1'b0;
      l2.busWdata <= ~d;
   endtask
   task automatic dr(input logic [1:0] a, input logic [7:0] e);
      @(posedge clock);
      l2.busAddr <= a;
      l2.busRead <= 1'b1;
      @(posedge clock);
      l2.busRead <= 1'b0;
      #1 chk8(l2.busRdata, e);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      test_done();
   end
   initial begin
      {rst, porRst, regWrite, regRead, fBusy, pdReq, regAddr, regWdata} = {2'b11, 4'h0, 3'h0, 8'h00};
      {l2.busAddr, l2.busWdata, l2.busWrite, l2.busRead} = {2'h0, 8'h00, 2'b00};
      {l2.globalIrqEnable, l2.flashSelfprogBusy, err_count, total_checks} = '0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      porRst <= 1'b0;
      foreach (ta[i]) begin
         hop(8'h01, ta[i], td[i]);
         hwait();
      end
      foreach (ta[i]) rb(ta[i], td[i]);
      foreach (ta[i]) begin
         hw(HOFS_CONFIG, {6'h00, i[1:0] + 2'h1});
         rb(ta[i], td[i]);
         hr(HOFS_STATUS);
         chk8(s & 8'h02, (i == 2) ? 8'h02 : 8'h00);
      end
      hr(3'h7);
      chk8(s, 8'h00);
      pdReq <= 1'b1;
      hop(8'h01, 11'h123, 8'h3C);
      wt(1'b1, 1'b0);
      chk8({6'h00, pdRdy, rcRun}, 8'h01);
      wt(1'b0, 1'b0);
      chk1(n >= WC * RD - 1 && n <= WC * RD + 2, 1'b1);
      chk8({6'h00, pdRdy, rcRun}, 8'h02);
      hwait();
      hop(8'h01, 11'h456, 8'hE7);
      wt(1'b1, 1'b0);
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      #1 chk1(wb, 1'b1);
      wt(1'b0, 1'b0);
      rb(11'h456, 8'hE7);
      fBusy <= 1'b1;
      hop(8'h01, 11'h055, 8'h66);
      repeat (30) @(posedge clock);
      #1 chk1(wb, 1'b0);
      @(posedge clock);
      fBusy <= 1'b0;
      hwait();
      rb(11'h055, 8'h66);
      dw(OFS_ADDR_HIGH, 8'hFF);
      dr(OFS_ADDR_HIGH, 8'h07);
      dw(OFS_ADDR_LOW, 8'h20);
      dw(OFS_DATA, 8'h99);
      dw(OFS_CONTROL, 8'h02);
      dr(OFS_CONTROL, 8'h00);
      dw(OFS_CONTROL, 8'h04);
      repeat (4) @(posedge clock);
      dw(OFS_CONTROL, 8'h02);
      dr(OFS_CONTROL, 8'h00);
      l2.flashSelfprogBusy <= 1'b1;
      dw(OFS_CONTROL, 8'h04);
      dw(OFS_CONTROL, 8'h02);
      repeat (3) @(posedge clock);
      l2.flashSelfprogBusy <= 1'b0;
      dr(OFS_CONTROL, 8'h00);
      dw(OFS_CONTROL, 8'h04);
      dw(OFS_CONTROL, 8'h02);
      dr(OFS_CONTROL, 8'h02);
      dw(OFS_ADDR_LOW, 8'h21);
      dr(OFS_ADDR_LOW, 8'h20);
      dw(OFS_DATA, 8'h11);
      dw(OFS_CONTROL, 8'h01);
      dr(OFS_DATA, 8'h11);
      dw(OFS_CONTROL, 8'h04);
      dw(OFS_CONTROL, 8'h02);
      wt(1'b0, 1'b1);
      dw(OFS_CONTROL, 8'h01);
      dr(OFS_DATA, 8'h99);
      test_done();
   end
endmodule
`default_nettype wire
